//--- hdl/hpfs_pin_mux.sv
// Host port pin-function select for the data lines and two shared address pins
// Operation
// RULE_01: The device offers an eight-bit parallel data port a host bus can attach to directly.
// RULE_02: Host function in plain bus style makes eight pins host data bits zero to seven.
// RULE_03: Host function in muxed bus style makes those pins shared address/data bits 0 to 7.
// RULE_04: In general-purpose use, bits zero to seven are each input, output or disconnected.
// RULE_05: After reset every pin is general-purpose and disconnected.
// RULE_06: Plain bus style with host function makes the first shared pin address bit zero.
// RULE_07: Muxed bus style makes the first shared pin an address strobe of set polarity.
// RULE_08: After reset the address strobe is taken as active low.
// RULE_09: Plain bus style with host function makes the second shared pin address bit one.
// RULE_10: Muxed bus style with host function makes the second shared pin address bit eight.
// RULE_11: In general-purpose use the two shared pins are port bits eight and nine.
// RULE_12: A disconnected pin never drives and its input level is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "hpfs_consts.svh"
module hpfs_pin_mux (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic [9:0]  pin_in,
  output logic      [9:0]  pin_out,
  output logic      [9:0]  pin_oe,
  output logic             host_addr_latch_strobe,
  output logic      [7:0]  host_rx_data,
  output logic             host_rx_valid
);
  logic [15:0]      ctrl;
  logic [9:0]       gpio_en;
  logic [9:0]       gpio_dir;
  logic [9:0]       gpio_out;
  logic [7:0]       host_tx_data;
  logic [9:0]       gpio_in;
  logic [9:0]       gpio_drv_oe;
  logic [9:0]       gpio_drv_val;
  logic             host_function_select;
  logic             muxed;
  logic             stb_high;
  logic             gpio_mode;
  logic             strobe_now;
  logic             strobe_prev;
  logic             host_addr_line_zero;
  logic             host_addr_line_one;
  logic             host_addr_line_eight;
  logic             wr_ctrl;
  logic             wr_gpio_en;
  logic             wr_gpio_dir;
  logic             wr_gpio_out;
  logic             wr_host_dout;
  logic             strobe_lead;
  logic             host_active;
  logic [7:0]       host_data_in;
  logic             host_shared_first;
  logic             host_shared_second;
  logic [15:0]      next_rdata;
  hpfs_pkg::hpfs_mode_t mode;

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] r);
    is_reg = (a == r);
  endfunction

  assign host_function_select = ctrl[`HPFS_CTRL_HOST_SEL];
  assign muxed                = ctrl[`HPFS_CTRL_MUXED];
  assign stb_high             = ctrl[`HPFS_CTRL_STB_HIGH];
  assign gpio_mode            = !host_function_select;

  always_comb begin
    if (!host_function_select) begin
      mode = hpfs_pkg::HPFS_MODE_GPIO;
    end else if (muxed) begin
      mode = hpfs_pkg::HPFS_MODE_HOST_MUXED;
    end else begin
      mode = hpfs_pkg::HPFS_MODE_HOST_PLAIN;
    end
  end

  // Host roles own the pins only while the host function is selected
  assign host_active = (mode != hpfs_pkg::HPFS_MODE_GPIO);

  // Host-side views of the pins: zero in general-purpose use, so a pin that is
  // disconnected or serving as a port bit never reaches the host capture logic
  assign host_data_in       = host_active ? pin_in[7:0] : 8'h00; // RULE_12
  assign host_shared_first  = host_active ? pin_in[8] : 1'b0;
  assign host_shared_second = host_active ? pin_in[9] : 1'b0;

  // One-hot write selects; an unmapped index selects nothing and the write is lost
  assign wr_ctrl      = wr && is_reg(addr, `HPFS_REG_CTRL);
  assign wr_gpio_en   = wr && is_reg(addr, `HPFS_REG_GPIO_EN);
  assign wr_gpio_dir  = wr && is_reg(addr, `HPFS_REG_GPIO_DIR);
  assign wr_gpio_out  = wr && is_reg(addr, `HPFS_REG_GPIO_OUT);
  assign wr_host_dout = wr && is_reg(addr, `HPFS_REG_HOST_DOUT);

  // Mode control resets to general-purpose use with the strobe active low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `HPFS_CTRL_RESET; // RULE_05 RULE_08
    end else if (wr_ctrl) begin
      ctrl <= {12'h000, wdata[3:0]};
    end
  end

  // Every port bit comes out of reset disconnected
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gpio_en <= 10'(`HPFS_GPIO_EN_RESET); // RULE_05
    end else if (wr_gpio_en) begin
      gpio_en <= wdata[9:0]; // RULE_04 RULE_11
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gpio_dir <= 10'(`HPFS_GPIO_DIR_RESET);
    end else if (wr_gpio_dir) begin
      gpio_dir <= wdata[9:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gpio_out <= 10'(`HPFS_GPIO_OUT_RESET);
    end else if (wr_gpio_out) begin
      gpio_out <= wdata[9:0];
    end
  end

  // Host transmit byte; it reaches the pins only while the host data drive bit is set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_tx_data <= 8'h00;
    end else if (wr_host_dout) begin
      host_tx_data <= wdata[7:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `HPFS_NUM_PINS; g++) begin : gen_bit
      hpfs_gpio_bit u_bit (
        .clk       (clk),
        .rstn      (rstn),
        .gpio_mode (gpio_mode),
        .enable    (gpio_en[g]),
        .dir_out   (gpio_dir[g]),
        .out_val   (gpio_out[g]),
        .pin_in    (pin_in[g]),
        .drive_oe  (gpio_drv_oe[g]),
        .drive_val (gpio_drv_val[g]),
        .in_val    (gpio_in[g])
      );
    end
  endgenerate

  // Pin drivers: shared pins 8 and 9 are inputs only in host function
  always_comb begin
    pin_oe  = 10'h000;
    pin_out = 10'h000;
    unique case (mode)
      hpfs_pkg::HPFS_MODE_GPIO: begin
        pin_oe  = gpio_drv_oe; // RULE_04 RULE_11
        pin_out = gpio_drv_val;
      end
      hpfs_pkg::HPFS_MODE_HOST_PLAIN,
      hpfs_pkg::HPFS_MODE_HOST_MUXED: begin
        pin_oe[7:0]  = {8{ctrl[`HPFS_CTRL_DATA_OE]}}; // RULE_01 RULE_02 RULE_03
        pin_out[7:0] = host_tx_data;
      end
    endcase
  end

  // Strobe polarity applied before use; pin is taken as already synchronous
  assign strobe_now = (mode == hpfs_pkg::HPFS_MODE_HOST_MUXED) &&
                      (host_shared_first == stb_high); // RULE_07 RULE_08
  assign host_addr_latch_strobe = strobe_now;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= strobe_now;
    end
  end

  // Leading edge of the strobe starts one address phase
  assign strobe_lead = strobe_now && !strobe_prev;

  // Plain style: the two shared pins are the low address bits, taken every cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_addr_line_zero <= 1'b0;
      host_addr_line_one  <= 1'b0;
    end else if (mode == hpfs_pkg::HPFS_MODE_HOST_PLAIN) begin
      host_addr_line_zero <= host_shared_first; // RULE_06
      host_addr_line_one  <= host_shared_second; // RULE_09
    end
  end

  // Muxed style: the second shared pin is address bit eight, held from strobe to strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_addr_line_eight <= 1'b0;
    end else if (strobe_lead) begin
      host_addr_line_eight <= host_shared_second; // RULE_10
    end
  end

  // Captured byte: every cycle in plain style, at the strobe's leading edge in muxed
  // style (the address phase), cleared in general-purpose use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_rx_data <= 8'h00;
    end else begin
      unique case (mode)
        hpfs_pkg::HPFS_MODE_HOST_PLAIN: begin
          host_rx_data <= host_data_in; // RULE_02
        end
        hpfs_pkg::HPFS_MODE_HOST_MUXED: begin
          if (strobe_lead) begin
            host_rx_data <= host_data_in; // RULE_03
          end
        end
        hpfs_pkg::HPFS_MODE_GPIO: begin
          host_rx_data <= 8'h00; // RULE_12
        end
      endcase
    end
  end

  // Valid: a level in plain style while the data lines are inputs, a one-cycle pulse
  // after each strobe leading edge in muxed style
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_rx_valid <= 1'b0;
    end else begin
      unique case (mode)
        hpfs_pkg::HPFS_MODE_HOST_PLAIN: begin
          host_rx_valid <= !ctrl[`HPFS_CTRL_DATA_OE];
        end
        hpfs_pkg::HPFS_MODE_HOST_MUXED: begin
          host_rx_valid <= strobe_lead;
        end
        hpfs_pkg::HPFS_MODE_GPIO: begin
          host_rx_valid <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (is_reg(addr, `HPFS_REG_CTRL)) begin
      next_rdata = ctrl;
    end else if (is_reg(addr, `HPFS_REG_GPIO_EN)) begin
      next_rdata = {6'h00, gpio_en};
    end else if (is_reg(addr, `HPFS_REG_GPIO_DIR)) begin
      next_rdata = {6'h00, gpio_dir};
    end else if (is_reg(addr, `HPFS_REG_GPIO_OUT)) begin
      next_rdata = {6'h00, gpio_out};
    end else if (is_reg(addr, `HPFS_REG_GPIO_IN)) begin
      next_rdata = {6'h00, gpio_in}; // RULE_12
    end else if (is_reg(addr, `HPFS_REG_HOST_ADDR)) begin
      next_rdata = {13'h0000, host_addr_line_eight, host_addr_line_one, host_addr_line_zero};
    end else if (is_reg(addr, `HPFS_REG_HOST_DOUT)) begin
      next_rdata = {8'h00, host_tx_data};
    end else if (is_reg(addr, `HPFS_REG_HOST_DIN)) begin
      next_rdata = {8'h00, host_rx_data};
    end
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

//--- hdl/hpfs_consts.svh
// Offsets, field positions and reset values for the host port pin mux
`ifndef HPFS_CONSTS_SVH
`define HPFS_CONSTS_SVH

`define HPFS_NUM_PINS        10
`define HPFS_ADDR_W          4
`define HPFS_DATA_W          16

`define HPFS_REG_CTRL        4'h0
`define HPFS_REG_GPIO_EN     4'h1
`define HPFS_REG_GPIO_DIR    4'h2
`define HPFS_REG_GPIO_OUT    4'h3
`define HPFS_REG_GPIO_IN     4'h4
`define HPFS_REG_HOST_ADDR   4'h5
`define HPFS_REG_HOST_DOUT   4'h6
`define HPFS_REG_HOST_DIN    4'h7

`define HPFS_CTRL_HOST_SEL   0
`define HPFS_CTRL_MUXED      1
`define HPFS_CTRL_STB_HIGH   2
`define HPFS_CTRL_DATA_OE    3

`define HPFS_CTRL_RESET      16'h0000
`define HPFS_GPIO_EN_RESET   16'h0000
`define HPFS_GPIO_DIR_RESET  16'h0000
`define HPFS_GPIO_OUT_RESET  16'h0000

`endif

//--- hdl/hpfs_pkg.sv
// Types shared by the host port pin mux files
package hpfs_pkg;
  typedef enum logic [1:0] {
    HPFS_MODE_GPIO,
    HPFS_MODE_HOST_PLAIN,
    HPFS_MODE_HOST_MUXED
  } hpfs_mode_t;
endpackage

//--- hdl/hpfs_gpio_bit.sv
// One general-purpose port bit: disconnected, input or output
`timescale 1ns/1ps
`default_nettype none
module hpfs_gpio_bit (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic gpio_mode,
  input  wire logic enable,
  input  wire logic dir_out,
  input  wire logic out_val,
  input  wire logic pin_in,
  output logic      drive_oe,
  output logic      drive_val,
  output logic      in_val
);
  // Disconnected bit never drives and never lets the pin level in
  assign drive_oe  = gpio_mode & enable & dir_out; // RULE_04 RULE_12
  assign drive_val = out_val;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_val <= 1'b0;
    end else if (gpio_mode && enable && !dir_out) begin // RULE_12
      in_val <= pin_in;
    end else begin
      in_val <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/hpfs_chk.sv
// Port checker for the host port pin mux
`timescale 1ns/1ps
`default_nettype none
module hpfs_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic [9:0]  pin_in,
  input wire logic [9:0]  pin_out,
  input wire logic [9:0]  pin_oe,
  input wire logic        host_addr_latch_strobe,
  input wire logic [7:0]  host_rx_data,
  input wire logic        host_rx_valid
);
  logic [15:0] sh [4];
  logic        hm;
  logic        mx;
  // Mirror of the setup registers, rebuilt from bus writes only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh <= '{default: 16'h0000};
    end else if (wr && addr[3:2] == 2'b00) begin
      sh[addr[1:0]] <= wdata;
    end
  end
  assign hm = sh[0][0];
  assign mx = sh[0][1];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_reset_quiet: assert property (disable iff (1'b0) !rstn |-> pin_oe == 10'h000)
    else $error("pin driven in reset");
  chk_gpio_dir: assert property (!hm |-> pin_oe == (sh[1][9:0] & sh[2][9:0]))
    else $error("gpio drive enable");
  chk_gpio_level: assert property (!hm |-> (pin_out & pin_oe) == (sh[3][9:0] & pin_oe))
    else $error("gpio drive level");
  chk_host_drive: assert property (hm |-> pin_oe == {2'b00, {8{sh[0][3]}}})
    else $error("host drive enable");
  chk_strobe_pol: assert property (hm && mx |-> host_addr_latch_strobe == (pin_in[8] ~^ sh[0][2]))
    else $error("strobe polarity");
  chk_strobe_off: assert property (!(hm && mx) |-> !host_addr_latch_strobe)
    else $error("strobe outside muxed mode");
  chk_mux_grab: assert property (hm && mx && $rose(host_addr_latch_strobe) |=>
    host_rx_valid && host_rx_data == $past(pin_in[7:0])) else $error("muxed capture");
  chk_plain_grab: assert property (hm && !mx && !sh[0][3] |=>
    host_rx_valid && host_rx_data == $past(pin_in[7:0])) else $error("plain capture");
  cover property (hm && mx && $rose(host_addr_latch_strobe));
  cover property (hm && !mx && host_rx_valid);
  cover property (!hm && pin_oe != 10'h000);
endmodule
`default_nettype wire

//--- tb/hpfs_host_model.sv
// Host bus model that drives or floats the port pins
`timescale 1ns/1ps
`default_nettype none
module hpfs_host_model (
  input  wire logic       clk,
  input  wire logic [9:0] host_val,
  input  wire logic [9:0] host_en,
  input  wire logic [9:0] pin_out,
  input  wire logic [9:0] pin_oe,
  output logic      [9:0] pin_in
);
  logic [9:0] churn = 10'h155;
  // Floating lines flip every cycle so a stale level never reads as valid
  always_ff @(posedge clk) churn <= ~churn;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((host_en & host_val) | (~host_en & churn)));
endmodule
`default_nettype wire

//--- tb/tb_hpfs_pin_mux.sv
// Self-checking bench for the host port pin mux
`timescale 1ns/1ps
`default_nettype none
module tb_hpfs_pin_mux;
  logic        clk = 1'b0;
  logic        rstn = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [9:0]  hv = 10'h000;
  logic [9:0]  he = 10'h000;
  logic [15:0] rdata;
  logic [9:0]  pin_in;
  logic [9:0]  pin_out;
  logic [9:0]  pin_oe;
  logic        stb;
  logic        rx_v;
  logic [7:0]  rx_d;
  int          err_count = 0;
  int          checked = 0;
  always #25 clk = ~clk;
  hpfs_pin_mux u_dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe,
    .host_addr_latch_strobe(stb), .host_rx_data(rx_d), .host_rx_valid(rx_v));
  hpfs_host_model u_host (.clk, .host_val(hv), .host_en(he), .pin_out, .pin_oe, .pin_in);
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata & m, exp);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    #1 cmp({6'h00, pin_oe}, 16'h0000);
    @(posedge clk) rstn <= 1'b1;
    rchk(4'h0, 16'hFFFF, 16'h0000);
    rchk(4'h1, 16'hFFFF, 16'h0000);
    $display("reset test done");
    @(posedge clk) he <= 10'h15F;
    hv <= 10'h1C3;
    wreg(4'h1, 16'hF3F0);
    wreg(4'h2, 16'h02A0);
    wreg(4'h3, 16'hFFFF);
    cmp({6'h00, pin_oe}, 16'h02A0);
    rchk(4'h4, 16'hFFFF, 16'h0140);
    rchk(4'h3, 16'hFFFF, 16'h03FF);
    rchk(4'hF, 16'hFFFF, 16'h0000);
    $display("gpio test done");
    @(posedge clk) he <= 10'h3FF;
    hv <= 10'h3A5;
    wreg(4'h0, 16'h0001);
    @(posedge clk) #1 cmp({7'h00, rx_v, rx_d}, 16'h01A5);
    rchk(4'h5, 16'hFFFF, 16'h0003);
    wreg(4'h6, 16'h003C);
    rchk(4'h6, 16'hFFFF, 16'h003C);
    @(posedge clk) he <= 10'h300;
    wreg(4'h0, 16'h0009);
    cmp({8'h00, pin_out[7:0]}, 16'h003C);
    $display("plain host test done");
    @(posedge clk) he <= 10'h3FF;
    hv <= 10'h35A;
    wreg(4'h0, 16'h0003);
    cmp({15'h0000, stb}, 16'h0000);
    @(posedge clk) hv <= 10'h25A;
    #1 cmp({15'h0000, stb}, 16'h0001);
    @(posedge clk) #1 cmp({7'h00, rx_v, rx_d}, 16'h015A);
    rchk(4'h7, 16'hFFFF, 16'h005A);
    rchk(4'h5, 16'h0004, 16'h0004);
    wreg(4'h0, 16'h0007);
    cmp({15'h0000, stb}, 16'h0000);
    @(posedge clk) hv <= 10'h15A;
    #1 cmp({15'h0000, stb}, 16'h0001);
    wreg(4'h0, 16'h0000);
    cmp({6'h00, pin_oe}, 16'h02A0);
    $display("muxed host test done");
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk) #1 cmp({6'h00, pin_oe}, 16'h0000);
    @(posedge clk) rstn <= 1'b1;
    rchk(4'h0, 16'hFFFF, 16'h0000);
    rchk(4'h2, 16'hFFFF, 16'h0000);
    $display("second reset test done");
    give_verdict();
  end
endmodule
bind hpfs_pin_mux hpfs_chk u_chk (.clk, .rstn, .addr, .wdata, .wr, .pin_in, .pin_out, .pin_oe,
  .host_addr_latch_strobe, .host_rx_data, .host_rx_valid);
`default_nettype wire
